//--- common/fcti_pkg.sv
package fcti_pkg;
   // ----------------------------------------
   // clock and source rates
   // ----------------------------------------
   localparam int unsigned CLK_HZ = 100_000_000;
   localparam int unsigned CLK_PERIOD_NS = 10;
   localparam int unsigned SRC_FAST_HZ = 4096;
   localparam int unsigned SRC_MID_HZ = 64;
   localparam int unsigned SRC_SEC_HZ = 1;
   localparam int unsigned SEC_PER_MIN = 60;
   localparam int unsigned FAST_DIV = CLK_HZ / SRC_FAST_HZ;
   localparam int unsigned MID_DIV = SRC_FAST_HZ / SRC_MID_HZ;
   localparam int unsigned SEC_DIV = SRC_MID_HZ / SRC_SEC_HZ;
   // return period of the repeat-mode low pulse
   localparam int unsigned RTN_NS = 10_000;
   localparam int unsigned RTN_CYC = (RTN_NS / CLK_PERIOD_NS < 1) ? 1 : RTN_NS / CLK_PERIOD_NS;
   // ----------------------------------------
   // register map: index, byte address = index * 4
   // ----------------------------------------
   localparam int AXI_AW = 8;
   localparam int AXI_DW = 32;
   localparam logic [7:0] REG_CTRL2_IDX = 8'h01;
   localparam logic [7:0] REG_TCTL_IDX = 8'h0e;
   localparam logic [7:0] REG_PRESET_IDX = 8'h0f;
   localparam logic [7:0] ADDR_CTRL2 = {REG_CTRL2_IDX[5:0], 2'h0};
   localparam logic [7:0] ADDR_TCTL = {REG_TCTL_IDX[5:0], 2'h0};
   localparam logic [7:0] ADDR_PRESET = {REG_PRESET_IDX[5:0], 2'h0};
   localparam int CTRL2_MODE_BIT = 4;
   localparam int CTRL2_TF_BIT = 2;
   localparam int CTRL2_TIE_BIT = 0;
   localparam int TCTL_RUN_BIT = 7;
   localparam int TCTL_PIN_BIT = 5;
   localparam logic [7:0] PRESET_RST = 8'h00;
   localparam logic [7:0] CNT_ONE = 8'h01;
   localparam logic [1:0] SRC_4096 = 2'h0;
   localparam logic [1:0] SRC_64 = 2'h1;
   localparam logic [1:0] SRC_1 = 2'h2;
   localparam logic [1:0] SRC_MIN = 2'h3;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // ----------------------------------------
   // types
   // ----------------------------------------
   typedef struct packed {
      logic [1:0] src_sel;
      logic run;
      logic mode;
      logic irq_en;
   } fcti_ctrl_t;
   localparam fcti_ctrl_t CTRL_RST = '{src_sel: SRC_4096, run: 1'b0, mode: 1'b0, irq_en: 1'b0};
   typedef enum logic [1:0] {FCTI_STOP = 2'b00, FCTI_COUNT = 2'b01} fcti_state_t;
endpackage

//--- logic/fcti_tick_div.sv
module fcti_tick_div
   import fcti_pkg::*;
#(
   parameter int unsigned DIV = 64
)
(
   input wire logic clk_in,
   input wire logic rst_b_in,
   input wire logic tick_in,
   output logic tick_out
);
   localparam int W = (DIV > 1) ? $clog2(DIV) : 1;
   localparam logic [W-1:0] LAST = W'(DIV - 1);
   logic [W-1:0] cnt_r;

   always_ff @(posedge clk_in)
   begin
      if (!rst_b_in)
         cnt_r <= '0;
      else if (tick_in)
         cnt_r <= (cnt_r == LAST) ? '0 : cnt_r + 1'b1;
   end

   always_ff @(posedge clk_in)
   begin
      if (!rst_b_in)
         tick_out <= 1'b0;
      else
         tick_out <= tick_in && (cnt_r == LAST);
   end
endmodule

//--- logic/fcti_ret_pulse.sv
module fcti_ret_pulse
   import fcti_pkg::*;
#(
   parameter int unsigned CYC = RTN_CYC
)
(
   input wire logic clk_in,
   input wire logic rst_b_in,
   input wire logic start_in,
   output logic busy_out
);
   localparam int W = (CYC > 1) ? $clog2(CYC) : 1;
   logic [W-1:0] cnt_r;

   // a new start restarts the full period
   always_ff @(posedge clk_in)
   begin
      if (!rst_b_in)
      begin
         cnt_r <= '0;
         busy_out <= 1'b0;
      end
      else if (start_in)
      begin
         cnt_r <= W'(CYC - 1);
         busy_out <= 1'b1;
      end
      else if (busy_out)
      begin
         if (cnt_r == '0)
            busy_out <= 1'b0;
         else
            cnt_r <= cnt_r - 1'b1;
      end
   end
endmodule

//--- logic/fcti_timer.sv
// How it works
// RULE1 - two-bit select picks 4096 Hz, 64 Hz, 1 Hz or 1/60 Hz ticks
// RULE2 - interval is source period times 8-bit setting, 1 to 255
// RULE3 - first tick unaligned, so interval lies between set time minus one tick and set time
// RULE4 - countdown starts from preset when run goes 0 to 1
// RULE5 - decrement once per tick; event when count goes 01h to 00h
// RULE6 - every event sets the event flag
// RULE7 - while running: count, event, reload preset, count again
// RULE8 - level mode: enable high at event drives irq low, else released
// RULE9 - while flag is set, enable directly drives or releases irq; code: level mode only, repeat mode enable gates pulse start
// RULE10 - flag holds until software clears; stopping keeps flag and irq
// RULE11 - level mode: clearing flag releases irq regardless of enable
// RULE12 - flag cleared while running: next 01h to 00h sets flag and irq again
// RULE13 - repeat mode reloads preset and restarts with no software action
// RULE14 - repeat mode: irq low for return period after each event, then released
// RULE15 - repeat mode: clearing flag does not shorten the low pulse
// RULE16 - repeat mode: each later event drives irq low even with flag set
// RULE17 - run going 1 to 0 stops the countdown
// RULE18 - host writes preset while stopped before each start
// RULE19 - host clears run, then flag, then enable before changing settings
// RULE20 - stopping invalidates counter and preset; preset must be rewritten
// RULE21 - writing 1 to flag does nothing; writing 0 clears it
// RULE22 - level mode: enable rising with event pending drives irq low at once
// RULE23 - irq is open drain: enable high means pin pulled low
module fcti_timer
   import fcti_pkg::*;
#(
   parameter int unsigned BASE_DIV = FAST_DIV,
   parameter int unsigned RET_CYC = RTN_CYC
)
(
   input wire logic clk_in,
   input wire logic rst_b_in,
   input wire logic [AXI_AW-1:0] s_axi_awaddr_in,
   input wire logic s_axi_awvalid_in,
   output logic s_axi_awready_out,
   input wire logic [AXI_DW-1:0] s_axi_wdata_in,
   input wire logic [AXI_DW/8-1:0] s_axi_wstrb_in,
   input wire logic s_axi_wvalid_in,
   output logic s_axi_wready_out,
   output logic [1:0] s_axi_bresp_out,
   output logic s_axi_bvalid_out,
   input wire logic s_axi_bready_in,
   input wire logic [AXI_AW-1:0] s_axi_araddr_in,
   input wire logic s_axi_arvalid_in,
   output logic s_axi_arready_out,
   output logic [AXI_DW-1:0] s_axi_rdata_out,
   output logic [1:0] s_axi_rresp_out,
   output logic s_axi_rvalid_out,
   input wire logic s_axi_rready_in,
   input wire logic timer_irq_out_n_in,
   output logic timer_irq_out_n_out,
   output logic timer_irq_out_n_oe_out
);
   // ----------------------------------------
   // declarations
   // ----------------------------------------
   fcti_ctrl_t ctrl_r;
   fcti_state_t state_r;
   logic [AXI_AW-1:0] aw_addr_r;
   logic [7:0] w_data_r;
   logic w_lane_r;
   logic [7:0] preset_r;
   logic preset_valid_r;
   logic [7:0] count_r;
   logic run_prev_r;
   logic tf_r;
   logic pin_r;
   logic tick_fast;
   logic tick_mid;
   logic tick_sec;
   logic tick_min;
   logic tick_sel;
   logic pulse_busy;
   logic wr_go;
   logic wr_ok;
   logic wr_ctrl2;
   logic wr_tctl;
   logic wr_preset;
   logic run_rise;
   logic run_fall;
   logic tmr_event;
   logic tf_clr;
   logic [7:0] rd_byte;
   logic rd_hit;

   // ----------------------------------------
   // source clock chain
   // ----------------------------------------
   fcti_tick_div #(.DIV(BASE_DIV)) u_div_fast (
      .clk_in(clk_in),
      .rst_b_in(rst_b_in),
      .tick_in(1'b1),
      .tick_out(tick_fast)
   );
   fcti_tick_div #(.DIV(MID_DIV)) u_div_mid (
      .clk_in(clk_in),
      .rst_b_in(rst_b_in),
      .tick_in(tick_fast),
      .tick_out(tick_mid)
   );
   fcti_tick_div #(.DIV(SEC_DIV)) u_div_sec (
      .clk_in(clk_in),
      .rst_b_in(rst_b_in),
      .tick_in(tick_mid),
      .tick_out(tick_sec)
   );
   fcti_tick_div #(.DIV(SEC_PER_MIN)) u_div_min (
      .clk_in(clk_in),
      .rst_b_in(rst_b_in),
      .tick_in(tick_sec),
      .tick_out(tick_min)
   );

   // prescaler runs free, so the first tick after start is unaligned
   always_comb
   begin
      case (ctrl_r.src_sel) // [RULE1] [RULE3]
         SRC_4096: tick_sel = tick_fast;
         SRC_64: tick_sel = tick_mid;
         SRC_1: tick_sel = tick_sec;
         SRC_MIN: tick_sel = tick_min;
         default: tick_sel = 1'b0;
      endcase
   end

   // ----------------------------------------
   // axi4-lite write channel
   // ----------------------------------------
   assign wr_go = !s_axi_awready_out && !s_axi_wready_out && !s_axi_bvalid_out;
   assign wr_ok = (aw_addr_r == ADDR_CTRL2) || (aw_addr_r == ADDR_TCTL) || (aw_addr_r == ADDR_PRESET);
   assign wr_ctrl2 = wr_go && w_lane_r && (aw_addr_r == ADDR_CTRL2);
   assign wr_tctl = wr_go && w_lane_r && (aw_addr_r == ADDR_TCTL);
   assign wr_preset = wr_go && w_lane_r && (aw_addr_r == ADDR_PRESET);

   // address and data are taken in either order, then held until the response
   always_ff @(posedge clk_in)
   begin
      if (!rst_b_in)
      begin
         s_axi_awready_out <= 1'b1;
         s_axi_wready_out <= 1'b1;
         s_axi_bvalid_out <= 1'b0;
         s_axi_bresp_out <= RESP_OKAY;
         aw_addr_r <= '0;
         w_data_r <= 8'h00;
         w_lane_r <= 1'b0;
      end
      else
      begin
         if (s_axi_awvalid_in && s_axi_awready_out)
         begin
            aw_addr_r <= s_axi_awaddr_in;
            s_axi_awready_out <= 1'b0;
         end
         if (s_axi_wvalid_in && s_axi_wready_out)
         begin
            w_data_r <= s_axi_wdata_in[7:0];
            w_lane_r <= s_axi_wstrb_in[0];
            s_axi_wready_out <= 1'b0;
         end
         if (wr_go)
         begin
            s_axi_bvalid_out <= 1'b1;
            s_axi_bresp_out <= wr_ok ? RESP_OKAY : RESP_SLVERR;
         end
         if (s_axi_bvalid_out && s_axi_bready_in)
         begin
            s_axi_bvalid_out <= 1'b0;
            s_axi_awready_out <= 1'b1;
            s_axi_wready_out <= 1'b1;
         end
      end
   end

   // ----------------------------------------
   // axi4-lite read channel
   // ----------------------------------------
   // preset address reads the live count while running; not latched, read twice
   always_comb
   begin
      rd_byte = 8'h00;
      rd_hit = 1'b1;
      case (s_axi_araddr_in)
         ADDR_CTRL2:
         begin
            rd_byte[CTRL2_MODE_BIT] = ctrl_r.mode;
            rd_byte[CTRL2_TF_BIT] = tf_r;
            rd_byte[CTRL2_TIE_BIT] = ctrl_r.irq_en;
         end
         ADDR_TCTL:
         begin
            rd_byte[TCTL_RUN_BIT] = ctrl_r.run;
            rd_byte[TCTL_PIN_BIT] = pin_r;
            rd_byte[1:0] = ctrl_r.src_sel;
         end
         ADDR_PRESET: rd_byte = (state_r == FCTI_COUNT) ? count_r : preset_r;
         default: rd_hit = 1'b0;
      endcase
   end

   always_ff @(posedge clk_in)
   begin
      if (!rst_b_in)
      begin
         s_axi_arready_out <= 1'b1;
         s_axi_rvalid_out <= 1'b0;
         s_axi_rdata_out <= '0;
         s_axi_rresp_out <= RESP_OKAY;
      end
      else if (s_axi_arvalid_in && s_axi_arready_out)
      begin
         s_axi_arready_out <= 1'b0;
         s_axi_rvalid_out <= 1'b1;
         s_axi_rdata_out <= {24'h000000, rd_byte};
         s_axi_rresp_out <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_rvalid_out && s_axi_rready_in)
      begin
         s_axi_rvalid_out <= 1'b0;
         s_axi_arready_out <= 1'b1;
      end
   end

   // ----------------------------------------
   // control bits
   // ----------------------------------------
   always_ff @(posedge clk_in)
   begin
      if (!rst_b_in)
         ctrl_r <= CTRL_RST;
      else
      begin
         if (wr_ctrl2)
         begin
            ctrl_r.mode <= w_data_r[CTRL2_MODE_BIT];
            ctrl_r.irq_en <= w_data_r[CTRL2_TIE_BIT];
         end
         if (wr_tctl)
         begin
            ctrl_r.run <= w_data_r[TCTL_RUN_BIT];
            ctrl_r.src_sel <= w_data_r[1:0];
         end
      end
   end

   always_ff @(posedge clk_in)
   begin
      if (!rst_b_in)
      begin
         run_prev_r <= 1'b0;
         pin_r <= 1'b1;
      end
      else
      begin
         run_prev_r <= ctrl_r.run;
         pin_r <= timer_irq_out_n_in;
      end
   end

   assign run_rise = ctrl_r.run && !run_prev_r;
   assign run_fall = !ctrl_r.run && run_prev_r;

   // ----------------------------------------
   // preset and down counter
   // ----------------------------------------
   // software must rewrite the preset after every stop
   always_ff @(posedge clk_in)
   begin
      if (!rst_b_in)
      begin
         preset_r <= PRESET_RST;
         preset_valid_r <= 1'b0;
      end
      else if (wr_preset)
      begin
         preset_r <= w_data_r; // [RULE18]
         preset_valid_r <= 1'b1;
      end
      else if (run_fall)
      begin
         preset_r <= PRESET_RST; // [RULE20]
         preset_valid_r <= 1'b0;
      end
   end

   assign tmr_event = (state_r == FCTI_COUNT) && tick_sel && (count_r == CNT_ONE); // [RULE5]

   // zero preset never starts: no interval is defined for it
   always_ff @(posedge clk_in)
   begin
      if (!rst_b_in)
      begin
         state_r <= FCTI_STOP;
         count_r <= 8'h00;
      end
      else
      begin
         case (state_r)
            FCTI_STOP:
            begin
               if (run_rise && preset_valid_r && (preset_r != 8'h00))
               begin
                  state_r <= FCTI_COUNT; // [RULE4]
                  count_r <= preset_r; // [RULE2]
               end
            end
            FCTI_COUNT:
            begin
               if (!ctrl_r.run)
               begin
                  state_r <= FCTI_STOP; // [RULE17]
                  count_r <= 8'h00; // [RULE20]
               end
               else if (tmr_event)
                  count_r <= preset_r; // [RULE7] [RULE13]
               else if (tick_sel)
                  count_r <= count_r - 1'b1; // [RULE5]
            end
            default:
            begin
               state_r <= FCTI_STOP;
               count_r <= 8'h00;
            end
         endcase
      end
   end

   // ----------------------------------------
   // event flag and interrupt pin
   // ----------------------------------------
   assign tf_clr = wr_ctrl2 && !w_data_r[CTRL2_TF_BIT]; // [RULE21]

   // a set in the same cycle as a clear wins; stopping leaves the flag alone
   always_ff @(posedge clk_in)
   begin
      if (!rst_b_in)
         tf_r <= 1'b0;
      else if (tmr_event)
         tf_r <= 1'b1; // [RULE6] [RULE12]
      else if (tf_clr)
         tf_r <= 1'b0; // [RULE10]
   end

   fcti_ret_pulse #(.CYC(RET_CYC)) u_ret (
      .clk_in(clk_in),
      .rst_b_in(rst_b_in),
      .start_in(tmr_event && ctrl_r.irq_en), // [RULE14] [RULE16]
      .busy_out(pulse_busy)
   );

   // repeat pulse ignores the flag, so a clear cannot cut it short
   always_ff @(posedge clk_in)
   begin
      if (!rst_b_in)
      begin
         timer_irq_out_n_out <= 1'b0;
         timer_irq_out_n_oe_out <= 1'b0;
      end
      else
      begin
         timer_irq_out_n_out <= 1'b0; // [RULE23]
         if (ctrl_r.mode)
            timer_irq_out_n_oe_out <= pulse_busy; // [RULE14] [RULE15]
         else
            timer_irq_out_n_oe_out <= tf_r && ctrl_r.irq_en; // [RULE8] [RULE9] [RULE11] [RULE22]
      end
   end

   // ----------------------------------------
   // assertions
   // ----------------------------------------
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rst_b_in);

   sequence s_rep_event;
      tmr_event && ctrl_r.mode && ctrl_r.irq_en;
   endsequence
   sequence s_start;
      state_r == FCTI_STOP && run_rise && preset_valid_r && preset_r != 8'h00;
   endsequence

   a_start_loads: assert property (s_start |=> state_r == FCTI_COUNT && count_r == $past(preset_r)) // [RULE4]
      else $error("start did not load preset");
   a_tick_decrement: assert property (state_r == FCTI_COUNT && ctrl_r.run && tick_sel && count_r > CNT_ONE
      |=> count_r == $past(count_r) - 8'h01) // [RULE5]
      else $error("count did not decrement on tick");
   a_count_idle: assert property (state_r == FCTI_COUNT && ctrl_r.run && !tick_sel |=> $stable(count_r)) // [RULE5]
      else $error("count moved without tick");
   a_event_reload: assert property (tmr_event && ctrl_r.run && !wr_preset
      |=> count_r == preset_r && tf_r) // [RULE7]
      else $error("event missed reload or flag");
   a_stop_halts: assert property ($fell(ctrl_r.run) |=> state_r == FCTI_STOP ##1 state_r == FCTI_STOP) // [RULE17]
      else $error("countdown not stopped");
   a_flag_holds: assert property (tf_r && !tf_clr |=> tf_r) // [RULE10]
      else $error("flag dropped without clear");
   a_write_one: assert property (wr_ctrl2 && w_data_r[CTRL2_TF_BIT] && !tf_r && !tmr_event |=> !tf_r) // [RULE21]
      else $error("writing one set the flag");
   a_level_release: assert property (!ctrl_r.mode && !tf_r ##1 !ctrl_r.mode && !tf_r
      |=> !timer_irq_out_n_oe_out) // [RULE11]
      else $error("irq held after flag clear");
   a_level_enable: assert property (!ctrl_r.mode && tf_r && $rose(ctrl_r.irq_en) |=> timer_irq_out_n_oe_out) // [RULE22]
      else $error("enable did not drive irq");
   a_repeat_fires: assert property (s_rep_event ##1 ctrl_r.mode |=> timer_irq_out_n_oe_out) // [RULE16]
      else $error("repeat event gave no pulse");
   a_repeat_hold: assert property (ctrl_r.mode && pulse_busy && tf_clr |=> timer_irq_out_n_oe_out) // [RULE15]
      else $error("flag clear cut repeat pulse");
   a_pin_low: assert property (timer_irq_out_n_out == 1'b0) // [RULE23]
      else $error("open drain data not low");
endmodule

//--- sim/fcti_irq_pullup.sv
// ----------------------------------------
// host side of the interrupt line
// ----------------------------------------
module fcti_irq_pullup
(
   input wire logic drive_low_in,
   input wire logic drive_val_in,
   output logic pin_n_out
);
   timeunit 1ns;
   timeprecision 100ps;
   // released line floats up via pull-up, never keeps the last driven level
   assign pin_n_out = drive_low_in ? drive_val_in : 1'b1;
endmodule

//--- sim/tb_fixed_cycle_timer_interrupt.sv
module tb_fixed_cycle_timer_interrupt;
   import fcti_pkg::*;
   timeunit 1ns;
   timeprecision 100ps;
   // ----------------------------------------
   // shortened counts so the run stays short
   // ----------------------------------------
   localparam int unsigned TB_DIV = 4;
   localparam int unsigned TB_RET = 8;
   logic clk_in = 1'b0;
   logic rst_b_in = 1'b0;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0, rdata;
   logic [3:0] wstrb = 4'h0;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic awready, wready, bvalid, arready, rvalid, oe, drv, pin_n;
   logic [1:0] bresp, rresp;
   int mismatches = 0;
   int samples_checked = 0;
   int cyc = 0;
   int t0, t1, t2;
   int divs[3] = '{4, 256, 16384};
   int pres[3] = '{4, 2, 1};
   logic [31:0] d;
   logic [1:0] r;

   always #5 clk_in = ~clk_in;
   always @(posedge clk_in) cyc <= cyc + 1;

   fcti_timer #(.BASE_DIV(TB_DIV), .RET_CYC(TB_RET)) dut_u (.clk_in(clk_in), .rst_b_in(rst_b_in),
      .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready),
      .s_axi_wdata_in(wdata), .s_axi_wstrb_in(wstrb), .s_axi_wvalid_in(wvalid), .s_axi_wready_out(wready),
      .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
      .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready),
      .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready),
      .timer_irq_out_n_in(pin_n), .timer_irq_out_n_out(drv), .timer_irq_out_n_oe_out(oe));

   fcti_irq_pullup host_u (.drive_low_in(oe), .drive_val_in(drv), .pin_n_out(pin_n));

   // ----------------------------------------
   // reporting
   // ----------------------------------------
   task automatic end_of_test();
      $display("mismatches %0d samples_checked %0d", mismatches, samples_checked);
      if (mismatches == 0 && samples_checked > 0)
      begin
         $display("No errors found");
      end
      else
      begin
         $display("Errors were found");
      end
      $finish;
   endtask

   task automatic check_val(input string what, input logic [31:0] exp, input logic [31:0] got);
      samples_checked++;
      if (got !== exp)
      begin
         mismatches++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic check_cnt(input string what, input int exp, input int got);
      samples_checked++;
      if (got != exp)
      begin
         mismatches++;
         $display("wrong value %s expected %0d seen %0d", what, exp, got);
      end
   endtask

   task automatic give_up(input string what);
      mismatches++;
      $display("wrong value %s expected an answer seen timeout", what);
      end_of_test();
   endtask

   // ----------------------------------------
   // bus master, one edge of spacing between transfers
   // ----------------------------------------
   task automatic axi_write(input logic [7:0] a, input logic [7:0] v, output logic [1:0] resp);
      int n;
      n = 0;
      @(posedge clk_in);
      awaddr <= a;
      awvalid <= 1'b1;
      wdata <= {24'h000000, v};
      wstrb <= 4'h1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do
      begin
         @(posedge clk_in);
         n++;
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
      end
      while (!bvalid && n < 100);
      if (!bvalid) give_up("write response");
      bready <= 1'b0;
      resp = bresp;
   endtask

   task automatic axi_read(input logic [7:0] a, output logic [31:0] v, output logic [1:0] resp);
      int n;
      n = 0;
      @(posedge clk_in);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do
      begin
         @(posedge clk_in);
         n++;
         if (arvalid && arready) arvalid <= 1'b0;
      end
      while (!rvalid && n < 100);
      if (!rvalid) give_up("read response");
      rready <= 1'b0;
      v = rdata;
      resp = rresp;
   endtask

   task automatic reg_wr(input logic [7:0] a, input logic [7:0] v);
      logic [1:0] rs;
      axi_write(a, v, rs);
      check_val("write response", {30'h0, RESP_OKAY}, {30'h0, rs});
   endtask

   task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] v;
      logic [1:0] rs;
      axi_read(a, v, rs);
      check_val("read response", {30'h0, RESP_OKAY}, {30'h0, rs});
      check_val(what, exp, v);
   endtask

   // at is -1 when the level never came
   task automatic wait_oe(input logic lvl, input int lim, output int at);
      int n;
      n = 0;
      do
      begin
         @(posedge clk_in);
         n++;
      end
      while (oe !== lvl && n < lim);
      at = (oe === lvl) ? cyc : -1;
   endtask

   task automatic need_oe(input logic lvl, input int lim, output int at);
      wait_oe(lvl, lim, at);
      if (at < 0) give_up("interrupt output");
   endtask

   // stop, clear flag and enable, preset while stopped, then start
   task automatic start(input logic m, input logic [7:0] p, input logic [1:0] s);
      reg_wr(ADDR_TCTL, 8'h00);
      reg_wr(ADDR_CTRL2, 8'h00);
      reg_wr(ADDR_PRESET, p);
      reg_wr(ADDR_CTRL2, {3'h0, m, 4'h1});
      reg_wr(ADDR_TCTL, {6'h20, s});
   endtask

   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial
   begin
      repeat (16) @(posedge clk_in);
      rst_b_in <= 1'b1;
      rd_chk("control reset", ADDR_CTRL2, 32'h0);
      rd_chk("timer control reset", ADDR_TCTL, 32'h20);
      rd_chk("preset reset", ADDR_PRESET, 32'h0);
      axi_read(8'h08, d, r);
      check_val("unmapped read", {30'h0, RESP_SLVERR}, {30'h0, r});
      check_val("unmapped data", 32'h0, d);
      axi_write(8'h08, 8'h5a, r);
      check_val("unmapped write", {30'h0, RESP_SLVERR}, {30'h0, r});
      reg_wr(ADDR_TCTL, 8'h03);
      rd_chk("minute select", ADDR_TCTL, 32'h23);
      // level mode interval for the 4096 Hz, 64 Hz and 1 Hz sources, also re-arm after clearing the flag
      for (int i = 0; i < 3; i++)
      begin
         start(1'b0, pres[i][7:0], i[1:0]);
         need_oe(1'b1, 2 * pres[i] * divs[i] + 50, t0);
         reg_wr(ADDR_CTRL2, 8'h01);
         need_oe(1'b0, 4, t1);
         need_oe(1'b1, 2 * pres[i] * divs[i], t1);
         check_cnt("event interval", pres[i] * divs[i], t1 - t0);
      end
      // flag set: enable alone moves the line
      reg_wr(ADDR_CTRL2, 8'h04);
      need_oe(1'b0, 4, t0);
      reg_wr(ADDR_CTRL2, 8'h05);
      need_oe(1'b1, 4, t0);
      rd_chk("flag after write one", ADDR_CTRL2, 32'h05);
      reg_wr(ADDR_TCTL, 8'h00);
      rd_chk("flag after stop", ADDR_CTRL2, 32'h05);
      check_val("line after stop", 32'h1, {31'h0, oe});
      check_val("open drain data", 32'h0, {31'h0, drv});
      rd_chk("pin level sensed", ADDR_TCTL, 32'h00);
      rd_chk("preset after stop", ADDR_PRESET, 32'h0);
      // restart with no fresh preset must stay idle
      reg_wr(ADDR_CTRL2, 8'h01);
      reg_wr(ADDR_TCTL, 8'h80);
      wait_oe(1'b1, 60, t0);
      check_cnt("start without preset", -1, t0);
      // stop in mid count halts events
      start(1'b0, 8'h04, SRC_4096);
      need_oe(1'b1, 60, t0);
      reg_wr(ADDR_TCTL, 8'h00);
      reg_wr(ADDR_CTRL2, 8'h01);
      wait_oe(1'b1, 60, t0);
      check_cnt("event after stop", -1, t0);
      // repeat mode pulses
      start(1'b1, 8'h08, SRC_4096);
      need_oe(1'b1, 80, t0);
      need_oe(1'b0, 20, t1);
      check_cnt("pulse length", TB_RET, t1 - t0);
      need_oe(1'b1, 40, t2);
      check_cnt("repeat period", 32, t2 - t0);
      reg_wr(ADDR_CTRL2, 8'h11);
      need_oe(1'b0, 20, t1);
      check_cnt("pulse after clear", TB_RET, t1 - t2);
      rd_chk("flag cleared", ADDR_CTRL2, 32'h11);
      reg_wr(ADDR_CTRL2, 8'h10);
      wait_oe(1'b1, 80, t0);
      check_cnt("pulse while disabled", -1, t0);
      end_of_test();
   end
endmodule
